// ### hw/serial_status_control.sv
/*
 * Second status register and third control register of an asynchronous
 * serial port with LIN support: break detection, edge flag, receiver busy
 * flag, polarity inversion, break length, ninth bits, single-wire direction
 * and receive error interrupt enables.
 * Assumes the baud logic gives one bit_tick per bit time, and the receive
 * and transmit shifters and status register one live outside this module.
 */
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/100ps
`default_nettype none
`include "serial_status_control_consts.svh"

module serial_status_control (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Receive pin and bit timing.
    input wire logic rx_pin,
    input wire logic bit_tick,
    input wire logic nine_bit_mode,
    // Receive shifter and status register one.
    input wire serial_status_control_pkg::rx_event_t rx_event,
    input wire logic receiver_standby,
    input wire serial_status_control_pkg::error_flags_t error_flags,
    output logic rx_line,
    output logic line_break_pulse,
    output logic rx_flag_inhibit,
    output logic idle_flag_set,
    // Data register and transmit shifter.
    input wire logic data_reg_write,
    input wire logic [7:0] data_reg_value,
    input wire logic tx_serial,
    output serial_status_control_pkg::tx_word_t tx_word,
    output logic [3:0] tx_break_bits,
    // Transmit pin and loop controls.
    input wire logic internal_return_select,
    input wire logic return_source_select,
    output logic tx_pin_out,
    output logic tx_pin_oe_n,
    // Error interrupt request.
    output logic error_irq
);

    // Software-visible bits of status register two.
    logic line_break_seen_flag;
    logic input_edge_flag;
    logic receive_polarity_invert;
    logic wake_idle_sets_idle_flag;
    logic long_break_select;
    logic line_break_detect_enable;
    logic receiver_busy_flag;

    // Bits of control register three.
    logic rx_ninth_bit;
    logic tx_ninth_bit;
    logic single_wire_drive_out;
    logic transmit_polarity_invert;
    logic overrun_irq_enable;
    logic noise_irq_enable;
    logic framing_irq_enable;
    logic parity_irq_enable;

    // Pin history and break counter.
    logic rx_pin_prev;
    logic [3:0] low_bits;
    logic break_reported;

    // Next values of the registers above except rx_pin_prev, and of the outputs.
    logic next_line_break_seen_flag;
    logic next_input_edge_flag;
    logic next_receive_polarity_invert;
    logic next_wake_idle_sets_idle_flag;
    logic next_long_break_select;
    logic next_line_break_detect_enable;
    logic next_receiver_busy_flag;
    logic next_rx_ninth_bit;
    logic next_tx_ninth_bit;
    logic next_single_wire_drive_out;
    logic next_transmit_polarity_invert;
    logic next_overrun_irq_enable;
    logic next_noise_irq_enable;
    logic next_framing_irq_enable;
    logic next_parity_irq_enable;
    logic [3:0] next_low_bits;
    logic next_break_reported;
    logic [7:0] next_reg_rdata;
    logic next_rx_line;
    logic next_line_break_pulse;
    logic next_idle_flag_set;
    serial_status_control_pkg::tx_word_t next_tx_word;
    logic [3:0] next_tx_break_bits;
    logic next_tx_pin_out;
    logic next_tx_pin_oe_n;
    logic next_error_irq;
    logic next_rx_flag_inhibit;

    // Helper terms.
    logic wr_s2;          // Write to status two this cycle.
    logic wr_c3;          // Write to control three this cycle.
    logic line_now;       // Receive input after polarity correction.
    logic edge_seen;      // Active edge on the raw pin.
    logic [3:0] detect_len; // Break detection threshold.
    logic break_hit;      // Threshold reached this bit time.
    logic [7:0] s2_view;  // Read view of status two.
    logic [7:0] c3_view;  // Read view of control three.

    // Decode, polarity, thresholds and read views.
    always_comb begin
        wr_s2 = reg_write && (reg_addr == `ADDR_STATUS_TWO);
        wr_c3 = reg_write && (reg_addr == `ADDR_CONTROL_THREE);
        // One inversion point feeds data, start, stop, break and idle alike.
        line_now = rx_pin ^ receive_polarity_invert;
        // Falling raw edge normally, rising raw edge when inverted.
        edge_seen = receive_polarity_invert ? (!rx_pin_prev && rx_pin)
                                            : (rx_pin_prev && !rx_pin);
        // Only the detection enable and nine-bit mode shape the threshold;
        // the long-break select is deliberately left out of this path.
        detect_len = (line_break_detect_enable ? `RX_BREAK_LIN : `RX_BREAK_NORMAL)
                     + {3'h0, nine_bit_mode};
        break_hit = bit_tick && !line_now && !break_reported
                    && ((low_bits + 4'h1) >= detect_len);
        s2_view = 8'h00; // Unused bit five stays zero.
        s2_view[`S2_BREAK_FLAG] = line_break_seen_flag;
        s2_view[`S2_EDGE_FLAG] = input_edge_flag;
        s2_view[`S2_RX_INVERT] = receive_polarity_invert;
        s2_view[`S2_WAKE_IDLE] = wake_idle_sets_idle_flag;
        s2_view[`S2_LONG_BREAK] = long_break_select;
        s2_view[`S2_BREAK_DETECT] = line_break_detect_enable;
        s2_view[`S2_BUSY] = receiver_busy_flag;
        c3_view = {rx_ninth_bit, tx_ninth_bit, single_wire_drive_out,
                   transmit_polarity_invert, overrun_irq_enable,
                   noise_irq_enable, framing_irq_enable, parity_irq_enable};
    end

    // Next state of registers, flags and registered outputs.
    always_comb begin
        // Stored control bits load from a write and otherwise hold.
        next_receive_polarity_invert = receive_polarity_invert;
        next_wake_idle_sets_idle_flag = wake_idle_sets_idle_flag;
        next_long_break_select = long_break_select;
        next_line_break_detect_enable = line_break_detect_enable;
        if (wr_s2) begin
            next_receive_polarity_invert = reg_wdata[`S2_RX_INVERT];
            next_wake_idle_sets_idle_flag = reg_wdata[`S2_WAKE_IDLE];
            next_long_break_select = reg_wdata[`S2_LONG_BREAK];
            next_line_break_detect_enable = reg_wdata[`S2_BREAK_DETECT];
        end
        next_tx_ninth_bit = tx_ninth_bit;
        next_single_wire_drive_out = single_wire_drive_out;
        next_transmit_polarity_invert = transmit_polarity_invert;
        next_overrun_irq_enable = overrun_irq_enable;
        next_noise_irq_enable = noise_irq_enable;
        next_framing_irq_enable = framing_irq_enable;
        next_parity_irq_enable = parity_irq_enable;
        if (wr_c3) begin
            // The ninth transmit bit holds until software rewrites it.
            next_tx_ninth_bit = reg_wdata[`C3_TX_NINTH];
            next_single_wire_drive_out = reg_wdata[`C3_DRIVE_OUT];
            next_transmit_polarity_invert = reg_wdata[`C3_TX_INVERT];
            next_overrun_irq_enable = reg_wdata[`C3_OVERRUN_IE];
            next_noise_irq_enable = reg_wdata[`C3_NOISE_IE];
            next_framing_irq_enable = reg_wdata[`C3_FRAMING_IE];
            next_parity_irq_enable = reg_wdata[`C3_PARITY_IE];
        end

        // Write-one-to-clear flags; a set in the same cycle wins.
        next_line_break_seen_flag = line_break_seen_flag;
        if (wr_s2 && reg_wdata[`S2_BREAK_FLAG]) begin
            next_line_break_seen_flag = 1'b0;
        end
        if (break_hit && line_break_detect_enable) begin
            next_line_break_seen_flag = 1'b1;
        end
        next_input_edge_flag = input_edge_flag;
        if (wr_s2 && reg_wdata[`S2_EDGE_FLAG]) begin
            next_input_edge_flag = 1'b0;
        end
        if (edge_seen) begin
            next_input_edge_flag = 1'b1;
        end

        // Busy flag: idle clears it, a start bit sets it and wins a tie.
        next_receiver_busy_flag = receiver_busy_flag;
        if (rx_event.idle_seen) begin
            next_receiver_busy_flag = 1'b0;
        end
        if (rx_event.start_seen) begin
            next_receiver_busy_flag = 1'b1;
        end

        // The ninth received bit follows each character that is buffered.
        // Under break detection the buffer is not filled, so it holds too.
        next_rx_ninth_bit = rx_ninth_bit;
        if (rx_event.char_load && !line_break_detect_enable) begin
            next_rx_ninth_bit = rx_event.ninth;
        end

        // Count whole bit times of low line; any high sample restarts it.
        next_low_bits = low_bits;
        next_break_reported = break_reported;
        if (line_now) begin
            next_low_bits = 4'h0;
            next_break_reported = 1'b0;
        end else if (bit_tick && !break_reported) begin
            next_low_bits = low_bits + 4'h1;
            if (break_hit) begin
                next_break_reported = 1'b1;
            end
        end

        // Registered outputs toward the rest of the serial port.
        next_reg_rdata = 8'h00; // Unmapped addresses read as zero.
        if (reg_read) begin
            if (reg_addr == `ADDR_STATUS_TWO) begin
                next_reg_rdata = s2_view;
            end else if (reg_addr == `ADDR_CONTROL_THREE) begin
                next_reg_rdata = c3_view;
            end
        end
        next_rx_line = line_now;
        next_line_break_pulse = break_hit;
        // Holds off framing and full flags while break detection is on.
        next_rx_flag_inhibit = next_line_break_detect_enable;
        // In standby the waking idle sets the idle flag only when enabled.
        next_idle_flag_set = rx_event.idle_seen
                             && (!receiver_standby || wake_idle_sets_idle_flag);
        // Use the incoming ninth bit so a same-cycle rewrite is not missed.
        next_tx_word.valid = data_reg_write;
        next_tx_word.word = {nine_bit_mode ? next_tx_ninth_bit : 1'b0,
                             data_reg_value};
        next_tx_break_bits = (long_break_select ? `TX_BREAK_LONG : `TX_BREAK_SHORT)
                             + {3'h0, nine_bit_mode};
        // Inversion sits at the pin, so idle and break flip too.
        next_tx_pin_out = tx_serial ^ transmit_polarity_invert;
        // Single-wire needs both loop controls; otherwise the pin drives.
        if (internal_return_select && return_source_select) begin
            next_tx_pin_oe_n = !single_wire_drive_out;
        end else begin
            next_tx_pin_oe_n = 1'b0;
        end
        // Pure OR of enabled flags: it drops as soon as the last one clears.
        next_error_irq = (overrun_irq_enable && error_flags.overrun)
                         || (noise_irq_enable && error_flags.noise)
                         || (framing_irq_enable && error_flags.framing)
                         || (parity_irq_enable && error_flags.parity);
    end

    // Registers only; every output comes straight from here.
    always_ff @(posedge clk_sys or posedge reset) begin
        if (reset) begin
            line_break_seen_flag <= 1'b0;
            input_edge_flag <= 1'b0;
            receive_polarity_invert <= 1'b0;
            wake_idle_sets_idle_flag <= 1'b0;
            long_break_select <= 1'b0;
            line_break_detect_enable <= 1'b0;
            receiver_busy_flag <= 1'b0;
            rx_ninth_bit <= 1'b0;
            tx_ninth_bit <= 1'b0;
            single_wire_drive_out <= 1'b0;
            transmit_polarity_invert <= 1'b0;
            overrun_irq_enable <= 1'b0;
            noise_irq_enable <= 1'b0;
            framing_irq_enable <= 1'b0;
            parity_irq_enable <= 1'b0;
            rx_pin_prev <= 1'b1;
            low_bits <= 4'h0;
            break_reported <= 1'b0;
            reg_rdata <= 8'h00;
            rx_line <= 1'b1;
            line_break_pulse <= 1'b0;
            rx_flag_inhibit <= 1'b0;
            idle_flag_set <= 1'b0;
            tx_word <= '0;
            tx_break_bits <= `TX_BREAK_SHORT;
            tx_pin_out <= 1'b1;
            tx_pin_oe_n <= 1'b0;
            error_irq <= 1'b0;
        end else begin
            line_break_seen_flag <= next_line_break_seen_flag;
            input_edge_flag <= next_input_edge_flag;
            receive_polarity_invert <= next_receive_polarity_invert;
            wake_idle_sets_idle_flag <= next_wake_idle_sets_idle_flag;
            long_break_select <= next_long_break_select;
            line_break_detect_enable <= next_line_break_detect_enable;
            receiver_busy_flag <= next_receiver_busy_flag;
            rx_ninth_bit <= next_rx_ninth_bit;
            tx_ninth_bit <= next_tx_ninth_bit;
            single_wire_drive_out <= next_single_wire_drive_out;
            transmit_polarity_invert <= next_transmit_polarity_invert;
            overrun_irq_enable <= next_overrun_irq_enable;
            noise_irq_enable <= next_noise_irq_enable;
            framing_irq_enable <= next_framing_irq_enable;
            parity_irq_enable <= next_parity_irq_enable;
            rx_pin_prev <= rx_pin;
            low_bits <= next_low_bits;
            break_reported <= next_break_reported;
            reg_rdata <= next_reg_rdata;
            rx_line <= next_rx_line;
            line_break_pulse <= next_line_break_pulse;
            rx_flag_inhibit <= next_rx_flag_inhibit;
            idle_flag_set <= next_idle_flag_set;
            tx_word <= next_tx_word;
            tx_break_bits <= next_tx_break_bits;
            tx_pin_out <= next_tx_pin_out;
            tx_pin_oe_n <= next_tx_pin_oe_n;
            error_irq <= next_error_irq;
        end
    end

endmodule : serial_status_control
`default_nettype wire

// ### hw/serial_status_control_consts.svh
/*
 * Offsets, field positions, reset values and break counts shared by the
 * serial status-two / control-three block.
 * Assumes an 8-bit register port and a bit-rate tick from the baud logic.
 */
`ifndef SERIAL_STATUS_CONTROL_CONSTS_SVH
`define SERIAL_STATUS_CONTROL_CONSTS_SVH

// Register addresses on the register port.
`define ADDR_STATUS_TWO 8'h00
`define ADDR_CONTROL_THREE 8'h01

// Reset values of both registers.
`define RESET_STATUS_TWO 8'h00
`define RESET_CONTROL_THREE 8'h00

// Status-two field positions.
`define S2_BREAK_FLAG 7
`define S2_EDGE_FLAG 6
`define S2_RX_INVERT 4
`define S2_WAKE_IDLE 3
`define S2_LONG_BREAK 2
`define S2_BREAK_DETECT 1
`define S2_BUSY 0

// Control-three field positions.
`define C3_RX_NINTH 7
`define C3_TX_NINTH 6
`define C3_DRIVE_OUT 5
`define C3_TX_INVERT 4
`define C3_OVERRUN_IE 3
`define C3_NOISE_IE 2
`define C3_FRAMING_IE 1
`define C3_PARITY_IE 0

// Break lengths in bit times, eight-bit mode; nine-bit mode adds one.
`define TX_BREAK_SHORT 4'hA
`define TX_BREAK_LONG 4'hD
`define RX_BREAK_NORMAL 4'hA
`define RX_BREAK_LIN 4'hB

`endif

// ### hw/serial_status_control_pkg.sv
/*
 * Types shared by the serial status-two / control-three block.
 * Assumes the constants header is included where offsets are needed.
 */
package serial_status_control_pkg;

    // Receiver events, each a one-cycle pulse from the receive shifter.
    typedef struct packed {
        logic start_seen;  // Beginning of a valid start bit.
        logic idle_seen;   // Idle line detected.
        logic char_load;   // Character moved into the receive buffer.
        logic ninth;       // Ninth bit of that character.
    } rx_event_t;

    // Receive error flags, as levels held in status register one.
    typedef struct packed {
        logic overrun;
        logic noise;
        logic framing;
        logic parity;
    } error_flags_t;

    // Word handed to the transmit shifter.
    typedef struct packed {
        logic valid;       // One-cycle pulse.
        logic [8:0] word;  // Ninth bit on top.
    } tx_word_t;

endpackage : serial_status_control_pkg

// ### verif/serial_status_control_checker.sv
/*
 * Concurrent checks on the ports of serial_status_control.
 * Assumes one clock domain and the register addresses of the constants header.
 */
`timescale 1ns/100ps
`default_nettype none
`include "serial_status_control_consts.svh"

module serial_status_control_checker (
    // Clock and reset.
    input wire logic clk_sys,
    input wire logic reset,
    // Register port.
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [7:0] reg_rdata,
    // Receive side.
    input wire logic bit_tick,
    input wire logic nine_bit_mode,
    input wire serial_status_control_pkg::rx_event_t rx_event,
    input wire serial_status_control_pkg::error_flags_t error_flags,
    input wire logic line_break_pulse,
    input wire logic rx_flag_inhibit,
    input wire logic idle_flag_set,
    // Transmit side.
    input wire logic data_reg_write,
    input wire logic [7:0] data_reg_value,
    input wire serial_status_control_pkg::tx_word_t tx_word,
    input wire logic [3:0] tx_break_bits,
    input wire logic internal_return_select,
    input wire logic return_source_select,
    input wire logic tx_pin_oe_n,
    input wire logic error_irq
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (reset);

    // The byte handed on one cycle after a data register write.
    sequence word_byte_s;
        tx_word.valid && tx_word.word[7:0] == $past(data_reg_value);
    endsequence
    // A break report lasts a single cycle.
    sequence pulse_end_s;
        ##1 !line_break_pulse;
    endsequence

    unmapped_read_a: assert property (reg_read && reg_addr > `ADDR_CONTROL_THREE |=> reg_rdata == 8'h00)
        else $error("unmapped read returned data");
    inhibit_follow_a: assert property (reg_write && reg_addr == `ADDR_STATUS_TWO |=> rx_flag_inhibit == $past(reg_wdata[1]))
        else $error("flag blocker does not follow detect enable");
    inhibit_hold_a: assert property (!(reg_write && reg_addr == `ADDR_STATUS_TWO) |=> $stable(rx_flag_inhibit))
        else $error("flag blocker moved without a write");
    word_launch_a: assert property (data_reg_write |-> ##1 word_byte_s)
        else $error("data write did not launch its byte");
    word_quiet_a: assert property (!data_reg_write |=> !tx_word.valid)
        else $error("word launched without a data write");
    eight_bit_a: assert property (data_reg_write && !nine_bit_mode |=> tx_word.word[8] == 1'b0)
        else $error("ninth bit sent in eight-bit mode");
    break_len_a: assert property (tx_break_bits inside {4'hA, 4'hB, 4'hD, 4'hE})
        else $error("break length outside the four lengths");
    break_pulse_a: assert property (line_break_pulse |-> $past(bit_tick) ##0 pulse_end_s)
        else $error("break report not tied to one bit tick");
    idle_cause_a: assert property (idle_flag_set |-> $past(rx_event.idle_seen))
        else $error("idle flag set without an idle event");
    pin_drive_a: assert property (!(internal_return_select && return_source_select) |=> !tx_pin_oe_n)
        else $error("transmit pin released outside single-wire mode");
    irq_quiet_a: assert property (error_flags == 4'h0 |=> !error_irq)
        else $error("error request without an error flag");
endmodule : serial_status_control_checker

bind serial_status_control serial_status_control_checker checker_inst (
    .clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata), .bit_tick(bit_tick),
    .nine_bit_mode(nine_bit_mode), .rx_event(rx_event), .error_flags(error_flags),
    .line_break_pulse(line_break_pulse), .rx_flag_inhibit(rx_flag_inhibit),
    .idle_flag_set(idle_flag_set), .data_reg_write(data_reg_write),
    .data_reg_value(data_reg_value), .tx_word(tx_word), .tx_break_bits(tx_break_bits),
    .internal_return_select(internal_return_select),
    .return_source_select(return_source_select), .tx_pin_oe_n(tx_pin_oe_n),
    .error_irq(error_irq));
`default_nettype wire

// ### verif/serial_node_model.sv
/*
 * Remote serial node: drives the receive line and the bit-rate tick.
 * Assumes one clock; the line idles high between frames.
 */
`timescale 1ns/100ps
`default_nettype none

module serial_node_model #(
    parameter int TICK_CYCLES = 4
) (
    // Clock.
    input wire logic clk_sys,
    // Line towards the receiver.
    output logic rx_pin,
    output logic bit_tick
);
    int cnt = 0;  // Cycle within the current bit time.

    // The line has a pull-up, so it rests high when nobody sends.
    initial begin
        rx_pin = 1'b1;
        bit_tick = 1'b0;
    end

    // Free-running tick; a slower node is simply a larger TICK_CYCLES.
    always @(posedge clk_sys) begin
        cnt <= (cnt == TICK_CYCLES - 1) ? 0 : cnt + 1;
        bit_tick <= (cnt == TICK_CYCLES - 1);
    end

    // Holds the line low for a number of bit times, as a break does.
    task hold_low(input int bits);
        rx_pin <= 1'b0;
        repeat (bits * TICK_CYCLES) @(posedge clk_sys);
        rx_pin <= 1'b1;
    endtask : hold_low
endmodule : serial_node_model
`default_nettype wire

// ### verif/serial_status_control_tb.sv
/*
 * Self-checking bench for serial_status_control.
 * Assumes the node model supplies rx_pin and bit_tick.
 */
`timescale 1ns/100ps
`default_nettype none
`include "serial_status_control_consts.svh"

module serial_status_control_tb;
    logic clk_sys, reset, reg_write, reg_read, nine_bit_mode, receiver_standby;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, data_reg_value, v, w;
    logic rx_pin, bit_tick, rx_line, line_break_pulse, rx_flag_inhibit, idle_flag_set;
    logic data_reg_write, tx_serial, internal_return_select, return_source_select;
    logic tx_pin_out, tx_pin_oe_n, error_irq;
    logic [3:0] tx_break_bits;
    serial_status_control_pkg::rx_event_t rx_event;
    serial_status_control_pkg::error_flags_t error_flags;
    serial_status_control_pkg::tx_word_t tx_word;
    integer fail_count = 0, tests_run = 0, seed = 32'h9736a159, ticks, k;

    serial_status_control DUT (.clk_sys(clk_sys), .reset(reset), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .rx_pin(rx_pin), .bit_tick(bit_tick),
        .nine_bit_mode(nine_bit_mode), .rx_event(rx_event),
        .receiver_standby(receiver_standby), .error_flags(error_flags), .rx_line(rx_line),
        .line_break_pulse(line_break_pulse), .rx_flag_inhibit(rx_flag_inhibit),
        .idle_flag_set(idle_flag_set), .data_reg_write(data_reg_write),
        .data_reg_value(data_reg_value), .tx_serial(tx_serial), .tx_word(tx_word),
        .tx_break_bits(tx_break_bits), .internal_return_select(internal_return_select),
        .return_source_select(return_source_select), .tx_pin_out(tx_pin_out),
        .tx_pin_oe_n(tx_pin_oe_n), .error_irq(error_irq));
    serial_node_model PN (.clk_sys(clk_sys), .rx_pin(rx_pin), .bit_tick(bit_tick));

    // 100 MHz clock.
    initial begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end

    // Compares one value; an unknown never counts as a match.
    task check(input string what, input logic [9:0] seen, input logic [9:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // One-cycle register write.
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr

    // One-cycle read; the data are looked at in the single cycle they stand.
    task rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        check(what, {2'b00, reg_rdata}, {2'b00, exp});
    endtask : rd

    // Sent break length in bit times.
    function automatic logic [3:0] brk_len(input logic lng, input logic m);
        return (lng ? 4'hD : 4'hA) + {3'b000, m};
    endfunction : brk_len

    // Prints the counts and the verdict, then stops.
    task complete_run;
        $display("comparisons %0d mismatches %0d", tests_run, fail_count);
        if (fail_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    // The whole sequence needs under five hundred cycles; forty times that means a hang.
    initial begin
        repeat (20000) @(posedge clk_sys);
        fail_count++;
        complete_run();
    end

    initial begin
        {reset, reg_write, reg_read, data_reg_write, nine_bit_mode, receiver_standby} = 6'h20;
        {reg_addr, reg_wdata, data_reg_value, rx_event, error_flags} = '0;
        {tx_serial, internal_return_select, return_source_select} = 3'b100;
        repeat (3) @(posedge clk_sys);
        reset <= 1'b0;
        rd(`ADDR_STATUS_TWO, `RESET_STATUS_TWO, "status reset");
        rd(`ADDR_CONTROL_THREE, `RESET_CONTROL_THREE, "control reset");
        // Random register values; flags stay zero, invert off so the idle pin is no break.
        for (k = 0; k < 8; k++) begin
            v = $random(seed);
            wr(`ADDR_STATUS_TWO, v & 8'hEF);
            rd(`ADDR_STATUS_TWO, v & 8'h0E, "status rw");
            wr(`ADDR_CONTROL_THREE, v);
            rd(`ADDR_CONTROL_THREE, v & 8'h7F, "control rw");
            rd(v | 8'h02, 8'h00, "unmapped");
        end
        $display("test registers done");
        // Four mixes of detect enable, long break and nine-bit mode, each setting both ways.
        for (k = 0; k < 4; k++) begin
            nine_bit_mode <= k[0];
            wr(`ADDR_STATUS_TWO, {5'b0, k[0] ^ k[1], k[1], 1'b0});
            ticks = 0;
            fork
                PN.hold_low(14);
                while (!line_break_pulse && ticks < 20) begin
                    @(negedge clk_sys);
                    if (!line_break_pulse && bit_tick && !rx_pin) ticks++;
                end
            join
            check("break ticks", 10'(ticks), 10'(10 + k[1] + k[0]));
            check("inhibit", rx_flag_inhibit, k[1]);
            check("break len", tx_break_bits, brk_len(k[0] ^ k[1], k[0]));
            rd(`ADDR_STATUS_TWO, {k[1], 4'b1000, k[0] ^ k[1], k[1], 1'b0}, "flags");
            wr(`ADDR_STATUS_TWO, 8'hC0);
            rd(`ADDR_STATUS_TWO, 8'h00, "flags clear");
        end
        $display("test break done");
        // Random transmit, pin and error request settings.
        for (k = 0; k < 12; k++) begin
            v = $random(seed);
            w = $random(seed);
            nine_bit_mode <= v[0];
            wr(`ADDR_CONTROL_THREE, v);
            data_reg_value <= ~v;
            data_reg_write <= 1'b1;
            tx_serial <= v[7];
            error_flags <= w[3:0];
            {internal_return_select, return_source_select} <= w[5:4];
            @(posedge clk_sys);
            data_reg_write <= 1'b0;
            @(negedge clk_sys);
            check("tx word", tx_word, {1'b1, v[0] & v[6], ~v});
            check("tx pin", tx_pin_out, v[7] ^ v[4]);
            check("pin dir", tx_pin_oe_n, w[4] & w[5] & ~v[5]);
            check("irq", error_irq, |(w[3:0] & v[3:0]));
        end
        $display("test transmit done");
        @(posedge clk_sys);
        rx_event <= 4'b1011;
        @(posedge clk_sys);
        rx_event <= 4'h0;
        rd(`ADDR_STATUS_TWO, 8'h01, "busy set");
        rd(`ADDR_CONTROL_THREE, {1'b1, v[6:0]}, "rx ninth");
        receiver_standby <= 1'b1;
        for (k = 0; k < 2; k++) begin
            wr(`ADDR_STATUS_TWO, {4'b0, k[0], 3'b0});
            rx_event <= 4'h4;
            @(posedge clk_sys);
            rx_event <= 4'h0;
            @(negedge clk_sys);
            check("idle flag", idle_flag_set, k[0]);
        end
        rd(`ADDR_STATUS_TWO, 8'h08, "busy clear");
        $display("test receiver done");
        // With inversion the rising edge is the active one.
        wr(`ADDR_STATUS_TWO, 8'h10);
        repeat (2) @(negedge clk_sys);
        check("rx line", rx_line, 1'b0);
        PN.hold_low(2);
        rd(`ADDR_STATUS_TWO, 8'h50, "inverted edge");
        $display("test inversion done");
        complete_run();
    end
endmodule : serial_status_control_tb
`default_nettype wire
